// File: design/psds_consts.svh
`ifndef PSDS_CONSTS_SVH
`define PSDS_CONSTS_SVH

// Register indices; the byte address is four times the index.
`define PSDS_IDX_DEADBAND   6'h1C
`define PSDS_IDX_SHUTDOWN   6'h1D
`define PSDS_IDX_STEER      6'h1E
`define PSDS_IDX_IRQ_STAT   6'h20
`define PSDS_IDX_IRQ_CLR    6'h21
`define PSDS_IDX_IRQ_EN     6'h22

// Reset values of the registers.
`define PSDS_RST_DEADBAND   8'h00
`define PSDS_RST_SHUTDOWN   8'h00
`define PSDS_RST_STEER      5'h01
`define PSDS_RST_IRQ        3'h0

// Field positions.
`define PSDS_BIT_RESTART    7
`define PSDS_BIT_FLAG       7
`define PSDS_BIT_STEER_SYNC 4

// Interrupt status bit positions.
`define PSDS_IRQ_SHUTDOWN   0
`define PSDS_IRQ_RESUME     1
`define PSDS_IRQ_STEER      2

// Mode encodings seen on the mode inputs.
`define PSDS_MODE_ENHANCED  2'h3
`define PSDS_CFG_SINGLE     2'h0
`define PSDS_CFG_HALF       2'h2

// Timing: one instruction cycle is four oscillator periods.
`define PSDS_CLK_PERIOD_NS  25
`define PSDS_TOSC_NS        25
`define PSDS_TOSC_PER_TCY   4
`define PSDS_TCY_CYCLES     ((`PSDS_TOSC_PER_TCY * `PSDS_TOSC_NS + \
    `PSDS_CLK_PERIOD_NS - 1) / `PSDS_CLK_PERIOD_NS)

`endif

// File: design/psds_deadband.sv
// Delays the rising edge of one active-high PWM signal by a number of
// instruction-cycle ticks; falling edges pass after one register stage.
module psds_deadband
    import psds_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       tick,
    input  wire logic [6:0] delay,
    input  wire logic       pwm_in,
    output logic            pwm_out
);

    logic       out_ff;    // Delayed output.
    logic       nxt_out;
    logic [6:0] cnt_ff;    // Ticks seen since the input went active.
    logic [6:0] nxt_cnt;

    // Count ticks while the input is active and still held off.
    always_comb
    begin
        nxt_out = out_ff;
        nxt_cnt = cnt_ff;
        if (!pwm_in)
        begin
            // Inactive-going edge is never delayed.
            nxt_out = 1'b0;
            nxt_cnt = 7'h00;
        end
        else if (!out_ff)
        begin
            if (cnt_ff >= delay)
                nxt_out = 1'b1;
            else if (tick)
                nxt_cnt = 7'(cnt_ff + 7'h01);
        end
    end

    // Register the delay state.
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            out_ff <= 1'b0;
            cnt_ff <= 7'h00;
        end
        else
        begin
            out_ff <= nxt_out;
            cnt_ff <= nxt_cnt;
        end
    end

    assign pwm_out = out_ff;

endmodule : psds_deadband

// File: design/psds_pkg.sv
package psds_pkg;

    // Dead-band and restart configuration register.
    typedef struct packed {
        logic       restart_auto_enable;
        logic [6:0] dead_delay_count;
    } psds_deadband_s;

    // Auto-shutdown control register.
    typedef struct packed {
        logic       shutdown_event_flag;
        logic [2:0] shutdown_source_select;
        logic [1:0] pair_ac_shutdown_state;
        logic [1:0] pair_bd_shutdown_state;
    } psds_shutdown_s;

    // Steering control register.
    typedef struct packed {
        logic       steer_sync_select;
        logic [3:0] steer_enable;
    } psds_steer_s;

    // Shutdown sequencing states, one-hot.
    typedef enum logic [2:0] {
        PSDS_RUN  = 3'b001,
        PSDS_SHUT = 3'b010,
        PSDS_WAIT = 3'b100
    } psds_state_e;

endpackage : psds_pkg

// File: design/psds_top.sv
`include "psds_consts.svh"

// Output conditioning of an enhanced PWM unit: steering synchronisation,
// dead band in half-bridge mode and auto-shutdown with restart.
module psds_top
    import psds_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [7:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic [3:0]  pwm_in,
    input  wire logic        period_start,
    input  wire logic [1:0]  pwm_mode_select,
    input  wire logic [1:0]  output_config_select,
    input  wire logic        cmp1_trip,
    input  wire logic        cmp2_trip,
    input  wire logic        int_pin_n,
    output logic             pwm_out_a,
    output logic             pwm_oe_a,
    output logic             pwm_out_b,
    output logic             pwm_oe_b,
    output logic             pwm_out_c,
    output logic             pwm_oe_c,
    output logic             pwm_out_d,
    output logic             pwm_oe_d,
    output logic             irq
);

    // Decode a pair shutdown state into {output enable, level}.
    function automatic logic [1:0] psds_sd_drive(input logic [1:0] st);
        logic [1:0] res;
        res = 2'h0;
        case (st)
            2'h0:    res = 2'h2;
            2'h1:    res = 2'h3;
            default: res = 2'h0;
        endcase
        return res;
    endfunction : psds_sd_drive

    // Trip inputs arrive from pins and other domains.
    logic [2:0]     meta_ff;        // First synchroniser stage.
    logic [2:0]     sync_ff;        // Second stage: {int_n, cmp2, cmp1}.
    logic [2:0]     nxt_meta;
    logic [2:0]     nxt_sync;
    // Bus slave state.
    logic           ack_ff;         // High in the cycle the bus is answered.
    logic           nxt_ack;
    logic [31:0]    rdata_ff;       // Read data captured on request.
    logic [31:0]    nxt_rdata;
    // Configuration and status registers.
    psds_deadband_s db_ff;
    psds_deadband_s nxt_db;
    psds_shutdown_s sd_ff;
    psds_shutdown_s nxt_sd;
    psds_steer_s    steer_ff;       // Software copy of steering.
    psds_steer_s    nxt_steer;
    logic [3:0]     steer_act_ff;   // Steering in force on the pins.
    logic [3:0]     nxt_steer_act;
    logic           pend_ff;        // Steering waiting for a period start.
    logic           nxt_pend;
    logic [2:0]     irq_stat_ff;    // Sticky event bits.
    logic [2:0]     nxt_irq_stat;
    logic [2:0]     irq_en_ff;      // Interrupt enables.
    logic [2:0]     nxt_irq_en;
    // Instruction-cycle divider and shutdown sequencer.
    logic [1:0]     div_ff;
    logic [1:0]     nxt_div;
    logic           tcy_tick;       // One pulse per instruction cycle.
    psds_state_e    state_ff;
    psds_state_e    nxt_state;
    // Pin registers, bit 0 is pin A.
    logic [3:0]     pin_out_ff;
    logic [3:0]     pin_oe_ff;
    logic [3:0]     nxt_pin_out;
    logic [3:0]     nxt_pin_oe;
    // Derived terms.
    logic [5:0]     idx;            // Word index of the bus address.
    logic           wr_go;          // Write takes effect this edge.
    logic           cause;          // Selected shutdown cause, a level.
    logic           hold;           // Outputs held in shutdown state.
    logic [1:0]     db_out;         // Dead-banded A and B.
    logic [3:0]     pwm_eff;        // Waveform offered to each pin.
    logic [3:0]     pin_en;         // Pins owned by the PWM.
    logic [1:0]     drv_ac;
    logic [1:0]     drv_bd;

    assign idx   = avs_address[7:2];
    assign wr_go = avs_write & ack_ff;

    // The selected sources form the cause; an all-zero select masks
    // every source, so only a software write of the flag can shut down.
    assign cause = |(sd_ff.shutdown_source_select &
                     {~sync_ff[2], sync_ff[1], sync_ff[0]});

    // Hold: the flag, a live cause, or the wait for a period edge.
    assign hold = sd_ff.shutdown_event_flag | cause |
                  (state_ff != PSDS_RUN);

    // Two-flop synchronisers; only the second stage is read.
    always_comb
    begin
        nxt_meta = {int_pin_n, cmp2_trip, cmp1_trip};
        nxt_sync = meta_ff;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            meta_ff <= 3'h4;
            sync_ff <= 3'h4;
        end
        else
        begin
            meta_ff <= nxt_meta;
            sync_ff <= nxt_sync;
        end
    end

    // Bus slave: one wait state, then the answer. Unmapped reads give
    // zero and unmapped writes are dropped.
    always_comb
    begin
        nxt_ack   = (avs_read | avs_write) & ~ack_ff;
        nxt_rdata = rdata_ff;
        if (avs_read && !ack_ff)
        begin
            case (idx)
                `PSDS_IDX_DEADBAND: nxt_rdata = {24'h0, db_ff};
                `PSDS_IDX_SHUTDOWN: nxt_rdata = {24'h0, sd_ff};
                `PSDS_IDX_STEER:    nxt_rdata = {27'h0, steer_ff};
                `PSDS_IDX_IRQ_STAT: nxt_rdata = {29'h0, irq_stat_ff};
                `PSDS_IDX_IRQ_EN:   nxt_rdata = {29'h0, irq_en_ff};
                default:            nxt_rdata = 32'h0;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            ack_ff   <= 1'b0;
            rdata_ff <= 32'h0;
        end
        else
        begin
            ack_ff   <= nxt_ack;
            rdata_ff <= nxt_rdata;
        end
    end

    assign avs_waitrequest = (avs_read | avs_write) & ~ack_ff;
    assign avs_readdata    = rdata_ff;

    // Registers, flag handling and steering update.
    always_comb
    begin
        nxt_db        = db_ff;
        nxt_sd        = sd_ff;
        nxt_steer     = steer_ff;
        nxt_steer_act = steer_act_ff;
        nxt_pend      = pend_ff;
        nxt_irq_en    = irq_en_ff;
        nxt_irq_stat  = irq_stat_ff;
        // Auto-restart drops the flag first, so a forced write still lands.
        if (db_ff.restart_auto_enable && !cause)
            nxt_sd.shutdown_event_flag = 1'b0;
        if (wr_go)
        begin
            case (idx)
                `PSDS_IDX_DEADBAND: nxt_db = avs_writedata[7:0];
                `PSDS_IDX_SHUTDOWN:
                begin
                    nxt_sd = avs_writedata[7:0];
                    // A clear only lands once the cause has gone.
                    nxt_sd.shutdown_event_flag =
                        avs_writedata[`PSDS_BIT_FLAG] |
                        (sd_ff.shutdown_event_flag & cause);
                end
                `PSDS_IDX_STEER:
                begin
                    nxt_steer = avs_writedata[4:0];
                    nxt_pend  = avs_writedata[`PSDS_BIT_STEER_SYNC];
                    if (!avs_writedata[`PSDS_BIT_STEER_SYNC])
                    begin
                        nxt_steer_act = avs_writedata[3:0];
                        nxt_irq_stat[`PSDS_IRQ_STEER] = 1'b1;
                    end
                end
                `PSDS_IDX_IRQ_CLR:
                    nxt_irq_stat = irq_stat_ff & ~avs_writedata[2:0];
                `PSDS_IDX_IRQ_EN:   nxt_irq_en = avs_writedata[2:0];
                default:            nxt_irq_en = irq_en_ff;
            endcase
        end
        // Deferred steering lands on the period edge.
        if (pend_ff && period_start)
        begin
            nxt_steer_act = steer_ff.steer_enable;
            nxt_pend      = 1'b0;
            nxt_irq_stat[`PSDS_IRQ_STEER] = 1'b1;
        end
        // A live cause sets the flag and beats any clear.
        if (cause)
            nxt_sd.shutdown_event_flag = 1'b1;
        // Event bits are set after the clear so that a set wins.
        if (nxt_sd.shutdown_event_flag && !sd_ff.shutdown_event_flag)
            nxt_irq_stat[`PSDS_IRQ_SHUTDOWN] = 1'b1;
        if (state_ff == PSDS_WAIT && nxt_state == PSDS_RUN)
            nxt_irq_stat[`PSDS_IRQ_RESUME] = 1'b1;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            db_ff        <= `PSDS_RST_DEADBAND;
            sd_ff        <= `PSDS_RST_SHUTDOWN;
            steer_ff     <= `PSDS_RST_STEER;
            steer_act_ff <= 4'(`PSDS_RST_STEER);
            pend_ff      <= 1'b0;
            irq_stat_ff  <= `PSDS_RST_IRQ;
            irq_en_ff    <= `PSDS_RST_IRQ;
        end
        else
        begin
            db_ff        <= nxt_db;
            sd_ff        <= nxt_sd;
            steer_ff     <= nxt_steer;
            steer_act_ff <= nxt_steer_act;
            pend_ff      <= nxt_pend;
            irq_stat_ff  <= nxt_irq_stat;
            irq_en_ff    <= nxt_irq_en;
        end
    end

    assign irq = |(irq_stat_ff & irq_en_ff);

    // Divider and shutdown sequencer. Resuming waits for a period edge
    // so the bridge never sees a truncated first pulse.
    always_comb
    begin
        nxt_div  = (div_ff == 2'(`PSDS_TCY_CYCLES - 1)) ?
                   2'h0 : 2'(div_ff + 2'h1);
        nxt_state = state_ff;
        case (state_ff)
            PSDS_RUN:
                if (sd_ff.shutdown_event_flag || cause)
                    nxt_state = PSDS_SHUT;
            PSDS_SHUT:
                if (!nxt_sd.shutdown_event_flag && !cause)
                    nxt_state = PSDS_WAIT;
            PSDS_WAIT:
                if (sd_ff.shutdown_event_flag || cause)
                    nxt_state = PSDS_SHUT;
                else if (period_start)
                    nxt_state = PSDS_RUN;
            default: nxt_state = PSDS_SHUT;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            div_ff   <= 2'h0;
            state_ff <= PSDS_RUN;
        end
        else
        begin
            div_ff   <= nxt_div;
            state_ff <= nxt_state;
        end
    end

    assign tcy_tick = (div_ff == 2'h0);

    // Dead band on the two half-bridge outputs A and B.
    genvar g;
    generate
        for (g = 0; g < 2; g++)
        begin : gen_db
            psds_deadband u_db (
                .clk     (clk),
                .rst_n   (rst_n),
                .tick    (tcy_tick),
                .delay   (db_ff.dead_delay_count),
                .pwm_in  (pwm_in[g]),
                .pwm_out (db_out[g])
            );
        end
    endgenerate

    assign drv_ac = psds_sd_drive(sd_ff.pair_ac_shutdown_state);
    assign drv_bd = psds_sd_drive(sd_ff.pair_bd_shutdown_state);

    // Pin drive. Pins not owned by the PWM are released whatever the
    // shutdown state, so shutdown only touches enabled pins.
    always_comb
    begin
        pwm_eff = pwm_in;
        if (output_config_select == `PSDS_CFG_HALF)
            pwm_eff[1:0] = db_out;
        case (output_config_select)
            `PSDS_CFG_SINGLE: pin_en = steer_act_ff;
            `PSDS_CFG_HALF:   pin_en = 4'h3;
            default:          pin_en = 4'hF;
        endcase
        if (pwm_mode_select != `PSDS_MODE_ENHANCED)
            pin_en = 4'h0;
        for (int i = 0; i < 4; i++)
        begin
            if (hold)
            begin
                nxt_pin_out[i] = pin_en[i] &
                    (i[0] ? drv_bd[0] : drv_ac[0]);
                nxt_pin_oe[i]  = pin_en[i] &
                    (i[0] ? drv_bd[1] : drv_ac[1]);
            end
            else
            begin
                nxt_pin_out[i] = pin_en[i] & pwm_eff[i];
                nxt_pin_oe[i]  = pin_en[i];
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            pin_out_ff <= 4'h0;
            pin_oe_ff  <= 4'h0;
        end
        else
        begin
            pin_out_ff <= nxt_pin_out;
            pin_oe_ff  <= nxt_pin_oe;
        end
    end

    assign pwm_out_a = pin_out_ff[0];
    assign pwm_oe_a  = pin_oe_ff[0];
    assign pwm_out_b = pin_out_ff[1];
    assign pwm_oe_b  = pin_oe_ff[1];
    assign pwm_out_c = pin_out_ff[2];
    assign pwm_oe_c  = pin_oe_ff[2];
    assign pwm_out_d = pin_out_ff[3];
    assign pwm_oe_d  = pin_oe_ff[3];

endmodule : psds_top

// File: verification/psds_bridge.sv
// Power bridge: A and C drive the high-side switches, B and D the
// low-side ones. Pull-downs keep a released pin, and its switch, off.
module psds_bridge
(
    input  wire logic [3:0] drv_out, // Levels from the four pins.
    input  wire logic [3:0] drv_oe,  // High while a pin is driven.
    output logic      [3:0] pin_lvl, // Level seen at the gate drivers.
    output logic            shoot    // Both switches of leg A/B are on.
);
    timeunit 1ns;
    timeprecision 100ps;

    // A driven pin shows its level; a released one is pulled low.
    always_comb
    begin
        pin_lvl = drv_out & drv_oe;
        shoot   = pin_lvl[0] && pin_lvl[1];
    end
endmodule : psds_bridge

// File: verification/psds_chk.sv
// Watches the pins against the shutdown, dead-band and bus behaviour.
module psds_chk
    import psds_pkg::*;
(
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic [7:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic        avs_waitrequest,
    input wire logic [3:0]  pwm_in,
    input wire logic        period_start,
    input wire logic [1:0]  pwm_mode_select,
    input wire logic [1:0]  output_config_select,
    input wire logic        cmp1_trip,
    input wire logic        cmp2_trip,
    input wire logic        int_pin_n,
    input wire logic        pwm_out_a,
    input wire logic        pwm_oe_a,
    input wire logic        pwm_out_b,
    input wire logic        pwm_oe_b,
    input wire logic        pwm_out_c,
    input wire logic        pwm_oe_c,
    input wire logic        pwm_out_d,
    input wire logic        pwm_oe_d
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    logic [6:0] sd_ff;   // Shadow of source select and pair states.
    logic [6:0] dd_ff;   // Shadow of the dead delay count.
    logic [1:0] hi_ff;   // Samples the selected cause has been high.
    logic       shut_ff; // The pins are owed the shutdown state.
    logic       wr_ok;   // A write is taken at this edge.
    logic       cause;   // Some selected source is tripped.
    logic       safe;    // Every enabled pin shows its pair state.
    logic       half;    // Enhanced mode with half-bridge outputs.

    // A pin passes when released, or when driving its pair's level.
    function automatic logic ok(logic oe, logic o, logic [1:0] s);
        return !oe || (!s[1] && o == s[0]);
    endfunction : ok

    assign wr_ok = avs_write && !avs_waitrequest;
    assign cause = |(sd_ff[6:4] & {!int_pin_n, cmp2_trip, cmp1_trip});
    assign safe  = ok(pwm_oe_a, pwm_out_a, sd_ff[3:2])
                 && ok(pwm_oe_c, pwm_out_c, sd_ff[3:2])
                 && ok(pwm_oe_b, pwm_out_b, sd_ff[1:0])
                 && ok(pwm_oe_d, pwm_out_d, sd_ff[1:0]);
    assign half  = pwm_mode_select == 2'h3 && output_config_select == 2'h2;

    // Shadows follow taken writes; the shut marker clears early so it
    // never asks more than the design owes.
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            sd_ff   <= 7'h00;
            dd_ff   <= 7'h00;
            hi_ff   <= 2'h0;
            shut_ff <= 1'b0;
        end
        else
        begin
            if (wr_ok && avs_address == 8'h74)
                sd_ff <= avs_writedata[6:0];
            if (wr_ok && avs_address == 8'h70)
                dd_ff <= avs_writedata[6:0];
            hi_ff <= !cause ? 2'h0 : (hi_ff == 2'h3 ? hi_ff : hi_ff + 2'h1);
            if ((cause && hi_ff >= 2'h2)
                || (wr_ok && avs_address == 8'h74 && avs_writedata[7]))
                shut_ff <= 1'b1;
            else if (period_start && !cause)
                shut_ff <= 1'b0;
        end
    end

    // Three samples of a selected trip level make a shutdown cause.
    sequence s_trip(logic sel, logic lvl);
        (sel && lvl)[*3];
    endsequence

    property p_wait;
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
    endproperty
    property p_cmp1;
        s_trip(sd_ff[4], cmp1_trip) |-> ##2 safe;
    endproperty
    property p_cmp2;
        s_trip(sd_ff[5], cmp2_trip) |-> ##2 safe;
    endproperty
    property p_int;
        s_trip(sd_ff[6], !int_pin_n) |-> ##2 safe;
    endproperty
    property p_hold;
        shut_ff && !period_start |=> safe;
    endproperty
    property p_force;
        wr_ok && avs_address == 8'h74 && avs_writedata[7] |-> ##2 safe;
    endproperty
    property p_dead_rise;
        half && !shut_ff && dd_ff == 7'h03 && $rose(pwm_in[0])
            |-> (!pwm_out_a)[*8] ##[1:10] pwm_out_a;
    endproperty
    property p_dead_fall;
        half && !shut_ff && $fell(pwm_in[0]) |-> ##[1:3] !pwm_out_a;
    endproperty
    property p_mode_off;
        (pwm_mode_select != 2'h3)[*2]
            |=> !(pwm_oe_a || pwm_oe_b || pwm_oe_c || pwm_oe_d);
    endproperty

    a_wait: assert property (p_wait)
        else $error("waitrequest not low in second cycle");
    a_cmp1: assert property (p_cmp1)
        else $error("comparator 1 trip did not reach the pins");
    a_cmp2: assert property (p_cmp2)
        else $error("comparator 2 trip did not reach the pins");
    a_int: assert property (p_int)
        else $error("interrupt pin trip did not reach the pins");
    a_hold: assert property (p_hold)
        else $error("pins left shutdown before a period start");
    a_force: assert property (p_force)
        else $error("software flag write did not shut the pins");
    a_dead_rise: assert property (p_dead_rise)
        else $error("active edge of pin A not delayed as set");
    a_dead_fall: assert property (p_dead_fall)
        else $error("inactive edge of pin A was delayed");
    a_mode_off: assert property (p_mode_off)
        else $error("pins driven outside enhanced mode");
endmodule : psds_chk

bind psds_top psds_chk u_chk (.*);

// File: verification/psds_tb.sv
module psds_tb;
    timeunit 1ns;
    timeprecision 100ps;

    logic        clk           = 1'b0;
    logic        rst_n         = 1'b0;
    logic [7:0]  avs_address   = 8'h00;
    logic        avs_read      = 1'b0;
    logic        avs_write     = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic [3:0]  pwm_in        = 4'h0;
    logic        period_start  = 1'b0;
    logic [1:0]  mode_sel      = 2'h0;
    logic [1:0]  cfg_sel       = 2'h0;
    logic        cmp1          = 1'b0;
    logic        cmp2          = 1'b0;
    logic        int_n         = 1'b1;
    logic [3:0]  pout;        // Pin levels {D,C,B,A}.
    logic [3:0]  poe;         // Pin enables {D,C,B,A}.
    logic [3:0]  pin_lvl;     // Wire levels seen by the bridge.
    logic        irq;
    logic        shoot;
    logic        shoot_seen    = 1'b0;
    logic        sh;          // The source under test is selected.
    logic [31:0] rd;          // Last read data.
    integer      num_errors    = 0;
    integer      checks_done   = 0;
    integer      n;
    logic [7:0]  ra [6] = '{8'h70, 8'h74, 8'h78, 8'h80, 8'h88, 8'hFC};
    logic [7:0]  re [6] = '{8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00};

    psds_top uut (
        .clk(clk), .rst_n(rst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .pwm_in(pwm_in),
        .period_start(period_start), .pwm_mode_select(mode_sel),
        .output_config_select(cfg_sel), .cmp1_trip(cmp1),
        .cmp2_trip(cmp2), .int_pin_n(int_n),
        .pwm_out_a(pout[0]), .pwm_oe_a(poe[0]),
        .pwm_out_b(pout[1]), .pwm_oe_b(poe[1]),
        .pwm_out_c(pout[2]), .pwm_oe_c(poe[2]),
        .pwm_out_d(pout[3]), .pwm_oe_d(poe[3]), .irq(irq));

    psds_bridge u_bridge (.drv_out(pout), .drv_oe(poe),
        .pin_lvl(pin_lvl), .shoot(shoot));

    // 40 MHz clock.
    initial
    begin
        forever #12.5 clk = ~clk;
    end

    // Shoot-through matters only in half-bridge mode.
    always @(posedge clk)
        if (cfg_sel == 2'h2 && shoot === 1'b1)
            shoot_seen <= 1'b1;

    task automatic cyc(input integer k);
        repeat (k) @(posedge clk);
    endtask : cyc

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done = checks_done + 1;
        if (seen !== exp)
        begin
            num_errors = num_errors + 1;
            $display("CHECK FAILED at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask : check

    // Holds the request until waitrequest is low at a rising edge.
    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= wr;
        avs_read      <= !wr;
        @(posedge clk);
        while (avs_waitrequest !== 1'b0)
            @(posedge clk);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
        @(posedge clk);
    endtask : bus

    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        bus(1'b0, a, 32'h0);
        check(rd, {24'h0, e});
    endtask : rchk

    // Compares pin enables and wire levels.
    task automatic pins(input logic [7:0] e);
        @(negedge clk);
        check({24'h0, poe, pin_lvl}, {24'h0, e});
        @(posedge clk);
    endtask : pins

    task automatic pulse();
        period_start <= 1'b1;
        @(posedge clk);
        period_start <= 1'b0;
        cyc(2);
    endtask : pulse

    task automatic trip(input int k, input logic on);
        cmp1  <= (k == 0) && on;
        cmp2  <= (k == 1) && on;
        int_n <= !((k == 2) && on);
    endtask : trip

    task automatic wrap_up();
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : wrap_up

    initial
    begin
        cyc(4);
        rst_n <= 1'b1;
        cyc(2);
        for (int i = 0; i < 6; i++)
            rchk(ra[i], re[i]);
        bus(1'b1, 8'h70, 32'hFF);
        rchk(8'h70, 8'hFF);
        bus(1'b1, 8'hFC, 32'hFF);
        rchk(8'hFC, 8'h00);
        rchk(8'h84, 8'h00);
        bus(1'b1, 8'h70, 32'h80);
        // Steering, then the interrupt path.
        mode_sel <= 2'h3;
        pwm_in   <= 4'hF;
        cyc(2);
        pins(8'h11);
        bus(1'b1, 8'h78, 32'h02);
        pins(8'h22);
        bus(1'b1, 8'h78, 32'h11);
        pins(8'h22);
        pulse();
        pins(8'h11);
        rchk(8'h80, 8'h04);
        check({31'h0, irq}, 32'h0);
        bus(1'b1, 8'h88, 32'h04);
        check({31'h0, irq}, 32'h1);
        bus(1'b1, 8'h84, 32'h04);
        rchk(8'h80, 8'h00);
        check({31'h0, irq}, 32'h0);
        // Every source code against every source, auto restart on.
        cfg_sel <= 2'h1;
        pwm_in  <= 4'hA;
        for (int s = 0; s < 8; s++)
            for (int k = 0; k < 3; k++)
            begin
                sh = s[k];
                bus(1'b1, 8'h74, {25'h0, s[2:0], 4'h4});
                trip(k, 1'b1);
                cyc(5);
                pins(sh ? 8'hF5 : 8'hFA);
                rchk(8'h74, {sh, s[2:0], 4'h4});
                trip(k, 1'b0);
                cyc(8);
                rchk(8'h74, {1'b0, s[2:0], 4'h4});
                pins(sh ? 8'hF5 : 8'hFA);
                pulse();
                pins(8'hFA);
            end
        // No auto restart; pair A/C released, pair B/D driven high.
        bus(1'b1, 8'h70, 32'h00);
        bus(1'b1, 8'h74, 32'h19);
        trip(0, 1'b1);
        cyc(5);
        pins(8'hAA);
        bus(1'b1, 8'h74, 32'h19);
        rchk(8'h74, 8'h99);
        trip(0, 1'b0);
        cyc(8);
        rchk(8'h74, 8'h99);
        pulse();
        pins(8'hAA);
        bus(1'b1, 8'h74, 32'h19);
        rchk(8'h74, 8'h19);
        pins(8'hAA);
        pulse();
        pins(8'hFA);
        bus(1'b1, 8'h74, 32'h80);
        pins(8'hF0);
        rchk(8'h74, 8'h80);
        bus(1'b1, 8'h74, 32'h00);
        pulse();
        pins(8'hFA);
        // Half bridge, dead delay of three instruction cycles.
        cfg_sel <= 2'h2;
        pwm_in  <= 4'h2;
        bus(1'b1, 8'h70, 32'h03);
        cyc(20);
        pwm_in <= 4'h1;
        n = 0;
        repeat (40)
        begin
            @(negedge clk);
            if (pout[0] !== 1'b1)
                n = n + 1;
        end
        @(posedge clk);
        check({31'h0, n >= 9 && n <= 16}, 32'h1);
        pwm_in <= 4'h2;
        cyc(40);
        check({31'h0, shoot_seen}, 32'h0);
        wrap_up();
    end

    // Watchdog, well beyond the run's length.
    initial
    begin
        repeat (20000) @(posedge clk);
        num_errors = num_errors + 1;
        wrap_up();
    end
endmodule : psds_tb
